// ---- dv/sitp_ctrl_model.sv ----
module sitp_ctrl_model
(
  input  wire  i_clk,
  input  wire  i_sda,
  output logic o_scl,
  output logic o_sda_lo
);
  timeunit 1ns;
  timeprecision 1ns;
  initial o_scl = 1'b1;
  initial o_sda_lo = 1'b0;
  task tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // 13-cycle halves keep the bus clock below 400 kHz
  task xbit(input logic b, output logic r);
    tick(6);
    o_sda_lo <= ~b;
    tick(7);
    o_scl <= 1'b1;
    tick(6);
    r = i_sda;
    tick(7);
    o_scl <= 1'b0;
  endtask
  task xbyte(input logic [7:0] t, input logic a, output logic [7:0] r,
             output logic k);
    for (int i = 7; i >= 0; i--)
      xbit(t[i], r[i]);
    xbit(a, k);
  endtask
  task start;
    tick(6);
    o_sda_lo <= 1'b0;
    tick(7);
    o_scl <= 1'b1;
    tick(13);
    o_sda_lo <= 1'b1;
    tick(13);
    o_scl <= 1'b0;
  endtask
  task stop;
    tick(6);
    o_sda_lo <= 1'b1;
    tick(7);
    o_scl <= 1'b1;
    tick(13);
    o_sda_lo <= 1'b0;
    tick(13);
  endtask
endmodule

// ---- dv/sitp_monitor.sv ----
`include "sitp_defines.vh"
module sitp_monitor
(
  input wire       i_clk,
  input wire       i_resetn,
  input wire       i_scl,
  input wire       i_sda,
  input wire       o_sda_o,
  input wire       o_sda_oe,
  input wire [7:0] o_reg_addr,
  input wire [7:0] o_wr_data,
  input wire       o_wr_en,
  input wire       o_rd_en,
  input wire [7:0] i_rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  a_drive_low: assert property (o_sda_o == 1'b0)
    else $error("drive high");
  a_wr_pulse: assert property (o_wr_en |=> !o_wr_en)
    else $error("wr pulse");
  a_ptr_inc: assert property
    (o_wr_en |=> o_reg_addr == $past(o_reg_addr) + 8'h01) else $error("ptr");
  a_wr_ack: assert property (o_wr_en |-> ##[0:1] o_sda_oe)
    else $error("no ack");
  a_ack_len: assert property ($rose(o_sda_oe) |=> o_sda_oe[*8])
    else $error("ack short");
  a_scl_high: assert property
    (i_scl && $past(i_scl) |-> $stable(o_sda_oe)) else $error("sda moved");
  a_rd_pulse: assert property (o_rd_en |=> !o_rd_en)
    else $error("rd pulse");
  a_fifo_stay: assert property
    (o_rd_en && $past(o_reg_addr) == `SITP_FIFO_IDX |->
     o_reg_addr == `SITP_FIFO_IDX) else $error("fifo ptr");
  a_one_strobe: assert property (!(o_wr_en && o_rd_en))
    else $error("both strobes");
endmodule
bind sitp_target sitp_monitor u_mon (.i_clk(i_clk), .i_resetn(i_resetn),
  .i_scl(i_scl), .i_sda(i_sda), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe),
  .o_reg_addr(o_reg_addr), .o_wr_data(o_wr_data), .o_wr_en(o_wr_en),
  .o_rd_en(o_rd_en), .i_rd_data(i_rd_data));

// ---- dv/sitp_tb.sv ----
`include "sitp_defines.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       i_clk = 1'b0;
  logic       i_resetn = 1'b0;
  logic [7:0] rd_q = 8'h00;
  logic [7:0] fq = 8'hc0;
  logic [7:0] mem [256];
  logic [7:0] rx;
  logic       k;
  int         n_fail = 0;
  int         tests_run = 0;
  wire        scl, sda_lo, oe, wr, rd, sdo;
  wire  [7:0] addr, wd;
  wire        sda = ~((oe & ~sdo) | sda_lo); // Pull-up wins when idle
  logic [7:0] r_idx [4] = '{8'h00, 8'h0e, 8'h11, 8'hfe};
  logic [7:0] r_dat [4] = '{8'h5a, 8'h81, 8'h00, 8'hff};
  sitp_ctrl_model m (.i_clk(i_clk), .i_sda(sda), .o_scl(scl),
    .o_sda_lo(sda_lo));
  sitp_target uut (.i_clk(i_clk), .i_resetn(i_resetn), .i_scl(scl),
    .i_sda(sda), .o_sda_o(sdo), .o_sda_oe(oe), .o_reg_addr(addr),
    .o_wr_data(wd), .o_wr_en(wr), .o_rd_en(rd), .i_rd_data(rd_q));
  initial forever #50 i_clk = ~i_clk;
  always @(posedge i_clk)
  begin
    if (wr)
      mem[addr] <= wd;
    if (rd)
      rd_q <= (addr == `SITP_FIFO_IDX) ? fq : mem[addr];
    if (rd && addr == `SITP_FIFO_IDX)
      fq <= fq + 8'h01;
  end
  task chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task send(input logic [7:0] b, input logic [7:0] e);
    m.xbyte(b, 1'b1, rx, k);
    chk({7'h00, k}, e);
  endtask
  task wr2(input logic [7:0] i, input logic [7:0] d);
    m.start;
    send(8'hae, 8'h00);
    send(i, 8'h00);
    send(d, 8'h00);
    send(~d, 8'h00);
    m.stop;
  endtask
  task rd2(input logic [7:0] i, input logic [7:0] e0, input logic [7:0] e1);
    m.start;
    send(8'hae, 8'h00);
    send(i, 8'h00);
    m.start;
    send(8'haf, 8'h00);
    m.xbyte(8'hff, 1'b0, rx, k);
    chk(rx, e0);
    m.xbyte(8'hff, 1'b1, rx, k);
    chk(rx, e1);
    m.stop;
  endtask
  task stop_test;
    $display("runs %0d fails %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge i_clk);
    i_resetn <= 1'b1;
    repeat (4) @(posedge i_clk);
    for (int j = 0; j < 4; j++)
    begin
      wr2(r_idx[j], r_dat[j]);
      rd2(r_idx[j], r_dat[j], ~r_dat[j]);
      chk(addr, r_idx[j] + 8'h02);
      $display("row %0d done", j);
    end
    rd2(`SITP_FIFO_IDX, 8'hc0, 8'hc1);
    chk(addr, `SITP_FIFO_IDX);
    m.start;
    send(8'h5e, 8'h01);
    send(8'hae, 8'h01);
    m.start;
    send(8'hac, 8'h01);
    m.stop;
    wr2(8'h20, 8'h3c);
    rd2(8'h20, 8'h3c, 8'hc3);
    m.start;
    send(8'hae, 8'h00);
    m.xbit(1'b0, k);
    m.xbit(1'b1, k);
    m.stop;
    // Idle target must neither ack nor drive these clocks
    m.xbyte(8'hff, 1'b1, rx, k);
    chk(rx, 8'hff);
    chk({7'h00, k}, 8'h01);
    $display("edge cases done");
    // Reset lands while the address ack is being driven
    m.start;
    rx = 8'hae;
    for (int n = 7; n >= 0; n--)
      m.xbit(rx[n], k);
    repeat (6) @(posedge i_clk);
    chk({7'h00, oe}, 8'h01);
    i_resetn <= 1'b0;
    repeat (16) @(posedge i_clk);
    chk({7'h00, oe}, 8'h00);
    chk(addr, `SITP_PTR_RST);
    i_resetn <= 1'b1;
    wr2(8'h30, 8'h99);
    rd2(8'h30, 8'h99, 8'h66);
    $display("reset done");
    stop_test;
  end
  initial
  begin
    #3000000;
    n_fail++;
    stop_test;
  end
endmodule

// ---- verilog/sitp_defines.vh ----
`ifndef SITP_DEFINES_VH
`define SITP_DEFINES_VH

`define SITP_CLK_HZ       10000000
`define SITP_SCL_MAX_HZ   400000
`define SITP_SCL_MIN_CYC  (`SITP_CLK_HZ / `SITP_SCL_MAX_HZ)

`define SITP_TARGET_ADDR  7'h57
`define SITP_FIFO_IDX     8'h10
`define SITP_BITS_BYTE    4'h8
`define SITP_RW_BIT       4'h7

`define SITP_PTR_RST      8'h00
`define SITP_LINE_RST     1'b1

`endif

// ---- verilog/sitp_sync.v ----
`include "sitp_defines.vh"

module sitp_sync
(
  input  wire       i_clk,    // System clock
  input  wire       i_resetn, // Synchronous reset, active low
  input  wire [1:0] i_async,  // Pin levels from outside the domain
  output wire [1:0] o_sync    // Two-flop synchronised levels
);

  reg [1:0] meta_q;
  reg [1:0] sync_q;

  // Reset to the idle-high bus level so no false start appears
  always @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      meta_q <= {2{`SITP_LINE_RST}};
      sync_q <= {2{`SITP_LINE_RST}};
    end
    else
    begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule

// ---- verilog/sitp_target.v ----
`include "sitp_defines.vh"

module sitp_target
(
  input  wire       i_clk,      // System clock, 10 MHz
  input  wire       i_resetn,   // Synchronous reset, active low
  input  wire       i_scl,      // Serial clock pin, input only
  input  wire       i_sda,      // Serial data pin level
  output reg        o_sda_o,    // Serial data drive value, always low
  output reg        o_sda_oe,   // High while pulling data line low
  output reg  [7:0] o_reg_addr, // Register pointer
  output reg  [7:0] o_wr_data,  // Byte to store
  output reg        o_wr_en,    // One-cycle store strobe
  output reg        o_rd_en,    // One-cycle fetch strobe
  input  wire [7:0] i_rd_data   // Fetched byte, valid cycle after strobe
);

  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_ADDR = 7'h02;
  localparam [6:0] S_ACK  = 7'h04;
  localparam [6:0] S_WR   = 7'h08;
  localparam [6:0] S_RD   = 7'h10;
  localparam [6:0] S_MACK = 7'h20;
  localparam [6:0] S_SKIP = 7'h40;

  wire [1:0] line_s;
  wire       scl_s;
  wire       sda_s;
  reg        scl_p_q;
  reg        sda_p_q;
  reg  [6:0] state_q;
  reg  [3:0] cnt_q;
  reg  [7:0] rx_q;
  reg  [7:0] tx_q;
  reg        rw_q;
  reg        idx_q;
  reg        mack_q;
  reg        start_hi_q;
  reg        cap_q;
  wire       scl_rise;
  wire       scl_fall;
  wire       start_c;
  wire       stop_c;

  // Expected address bit for position n, first bit is the MSB
  function addr_bit;
    input [3:0] n;
    reg   [6:0] a;
    begin
      a        = `SITP_TARGET_ADDR;
      addr_bit = a[3'h6 - n[2:0]];
    end
  endfunction

  // Next pointer; the FIFO data register holds its place
  function [7:0] adv;
    input [7:0] p;
    begin
      if (p == `SITP_FIFO_IDX)
        adv = p;
      else
        adv = p + 8'h01;
    end
  endfunction

  // 25 system clocks per fastest bus period leave margin for sync delay
  sitp_sync u_sync
  (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_async  ({i_scl, i_sda}),
    .o_sync   (line_s)
  );

  assign scl_s    = line_s[1];
  assign sda_s    = line_s[0];
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign start_c  = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_c   = scl_s & scl_p_q & ~sda_p_q & sda_s;

  always @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      scl_p_q    <= `SITP_LINE_RST;
      sda_p_q    <= `SITP_LINE_RST;
      state_q    <= S_IDLE;
      cnt_q      <= 4'h0;
      rx_q       <= 8'h00;
      tx_q       <= 8'h00;
      rw_q       <= 1'b0;
      idx_q      <= 1'b0;
      mack_q     <= 1'b0;
      start_hi_q <= 1'b0;
      cap_q      <= 1'b0;
      o_sda_o    <= 1'b0;
      o_sda_oe   <= 1'b0;
      o_reg_addr <= `SITP_PTR_RST;
      o_wr_data  <= 8'h00;
      o_wr_en    <= 1'b0;
      o_rd_en    <= 1'b0;
    end
    else
    begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      o_sda_o <= 1'b0;
      o_wr_en <= 1'b0;
      o_rd_en <= 1'b0;
      cap_q   <= o_rd_en;
      if (cap_q)
        tx_q <= i_rd_data;
      if (o_wr_en)
        o_reg_addr <= o_reg_addr + 8'h01;
      if (scl_fall)
        start_hi_q <= 1'b0;

      if (start_c)
      begin
        // Repeated start reopens addressing without an idle pass
        state_q    <= S_ADDR;
        cnt_q      <= 4'h0;
        o_sda_oe   <= 1'b0;
        start_hi_q <= 1'b1;
      end
      else if (stop_c && !start_hi_q)
      begin
        state_q  <= S_IDLE;
        o_sda_oe <= 1'b0;
      end
      else
      begin
        case (state_q)
          S_ADDR:
          begin
            if (scl_rise)
            begin
              cnt_q <= cnt_q + 4'h1;
              if (cnt_q == `SITP_RW_BIT)
                rw_q <= sda_s;
              else if (sda_s != addr_bit(cnt_q))
                state_q <= S_SKIP;
            end
            else if (scl_fall && cnt_q == `SITP_BITS_BYTE)
            begin
              state_q  <= S_ACK;
              o_sda_oe <= 1'b1;
              idx_q    <= ~rw_q;
              o_rd_en  <= rw_q;
            end
          end
          S_ACK:
          begin
            if (scl_fall)
            begin
              cnt_q <= 4'h0;
              if (rw_q)
              begin
                state_q  <= S_RD;
                o_sda_oe <= ~tx_q[7];
              end
              else
              begin
                state_q  <= S_WR;
                o_sda_oe <= 1'b0;
              end
            end
          end
          S_WR:
          begin
            if (scl_rise)
            begin
              rx_q  <= {rx_q[6:0], sda_s};
              cnt_q <= cnt_q + 4'h1;
            end
            else if (scl_fall && cnt_q == `SITP_BITS_BYTE)
            begin
              if (idx_q)
              begin
                o_reg_addr <= rx_q;
                idx_q      <= 1'b0;
              end
              else
              begin
                o_wr_data <= rx_q;
                o_wr_en   <= 1'b1;
              end
              state_q  <= S_ACK;
              o_sda_oe <= 1'b1;
            end
          end
          S_RD:
          begin
            if (scl_rise)
              cnt_q <= cnt_q + 4'h1;
            else if (scl_fall)
            begin
              if (cnt_q == `SITP_BITS_BYTE)
              begin
                state_q  <= S_MACK;
                o_sda_oe <= 1'b0;
              end
              else
              begin
                tx_q     <= {tx_q[6:0], 1'b0};
                o_sda_oe <= ~tx_q[6];
              end
            end
          end
          S_MACK:
          begin
            if (scl_rise)
            begin
              mack_q     <= ~sda_s;
              o_reg_addr <= adv(o_reg_addr);
              // Fetch only on ack so a FIFO is never popped for nothing
              o_rd_en    <= ~sda_s;
            end
            else if (scl_fall)
            begin
              cnt_q <= 4'h0;
              if (mack_q)
              begin
                state_q  <= S_RD;
                o_sda_oe <= ~tx_q[7];
              end
              else
                state_q <= S_SKIP;
            end
          end
          S_SKIP:
            o_sda_oe <= 1'b0;
          S_IDLE:
            o_sda_oe <= 1'b0;
          default:
          begin
            state_q  <= S_IDLE;
            o_sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule
